// ===== rtl/lbag_pkg.sv
/*
 * Shared constants for the localbuffer address generator: register
 * offsets, field positions, reset values, widths, states and the
 * partial-product term used to form the row count times screen width.
 * Assumes one core clock and an APB register bus with 32-bit data.
 */
package lbag_pkg;

	// widths
	localparam int ADDR_W    = 24;
	localparam int COORD_W   = 16;
	localparam int SI_W      = 8;
	localparam int PP_W      = 3;
	localparam int TEXIDX_W  = 24;
	localparam int PAGE_BITS = 9;
	localparam int ROW_W     = ADDR_W - PAGE_BITS;
	localparam int RM_W      = 10;

	// register byte offsets
	localparam logic [7:0] REG_READ_MODE = 8'h00;
	localparam logic [7:0] REG_WIN_BASE  = 8'h04;
	localparam logic [7:0] REG_SRC_OFF   = 8'h08;
	localparam logic [7:0] REG_SCREEN    = 8'h0c;
	localparam logic [7:0] REG_SCAN_INT  = 8'h10;
	localparam logic [7:0] REG_TEX_CFG   = 8'h14;
	localparam logic [7:0] REG_TEX_BASE  = 8'h18;
	localparam logic [7:0] REG_STATUS    = 8'h1c;
	localparam logic [7:0] REG_COUNTS    = 8'h20;

	// field positions
	localparam int RM_ORIGIN_BIT = 0;
	localparam int RM_PPA_LSB    = 1;
	localparam int RM_PPB_LSB    = 4;
	localparam int RM_PPC_LSB    = 7;
	localparam int SCR_W_LSB     = 0;
	localparam int SCR_H_LSB     = 16;
	localparam int PP_BASE_SHIFT = 4;

	// reset values
	localparam logic [SI_W-1:0] RST_SCAN_INT  = 8'h01;
	localparam logic [15:0]     RST_SCR_EXT   = 16'hffff;

	// texel depth codes: 32, 16, 8 or 4 bits per texel
	localparam logic [1:0] TEX_D32 = 2'h0;
	localparam logic [1:0] TEX_D16 = 2'h1;
	localparam logic [1:0] TEX_D8  = 2'h2;
	localparam logic [1:0] TEX_D4  = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DIVIDE,
		ST_ADDRESS,
		ST_ISSUE
	} lbag_state_t;

	// one partial product: zero, or the row count shifted left
	function automatic logic [ADDR_W-1:0] ppTerm(
		input logic [PP_W-1:0]    sel,
		input logic [COORD_W-1:0] rows
	);
		logic [ADDR_W-1:0] wide;
		wide = {{(ADDR_W-COORD_W){1'b0}}, rows};
		if (sel == 3'h0)
			ppTerm = '0;
		else
			ppTerm = wide << (32'(sel) + PP_BASE_SHIFT);
	endfunction

endpackage

// ===== rtl/lbag_calc_if.sv
/*
 * Carrier between the address generator and its two arithmetic
 * helpers: the scanline divider and the partial-product summer.
 * Assumes all three share core_clk.
 */
`timescale 1ns/1ps
interface lbag_calc_if;
	import lbag_pkg::*;
	logic                start;
	logic [COORD_W-1:0]  dividend;
	logic [SI_W-1:0]     divisor;
	logic                done;
	logic [COORD_W-1:0]  quotient;
	logic [PP_W-1:0]     ppA;
	logic [PP_W-1:0]     ppB;
	logic [PP_W-1:0]     ppC;
	logic [ADDR_W-1:0]   product;

	modport ctrl (output start, dividend, divisor, ppA, ppB, ppC,
		input done, quotient, product);
	modport div (input start, dividend, divisor, output done, quotient);
	modport mult (input quotient, ppA, ppB, ppC, output product);
endinterface

// ===== rtl/lbag_y_divider.sv
/*
 * Sequential restoring divider for Y over the scanline interval.
 * Assumes start is a one-cycle pulse while idle; done pulses once.
 */
`timescale 1ns/1ps
module lbag_y_divider
	import lbag_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// operands and result
	lbag_calc_if.div  calc
);
	typedef struct packed {
		logic               busy;
		logic               done;
		logic [4:0]         cnt;
		logic [SI_W:0]      rem;
		logic [COORD_W-1:0] quo;
		logic [SI_W-1:0]    dvs;
	} lbag_div_t;

	lbag_div_t q;
	lbag_div_t d;
	logic [SI_W:0] trial;

	// one quotient bit per cycle, or a pass-through for interval 0 or 1
	always_comb begin
		d = q;
		d.done = 1'b0;
		trial = {q.rem[SI_W-1:0], q.quo[COORD_W-1]};
		if (calc.start) begin
			d.quo = calc.dividend;
			d.rem = '0;
			d.dvs = calc.divisor;
			d.cnt = 5'(COORD_W);
			if (calc.divisor <= 8'h01) begin
				d.done = 1'b1;
			end else begin
				d.busy = 1'b1;
			end
		end else if (q.busy) begin
			if (trial >= {1'b0, q.dvs}) begin
				d.rem = trial - {1'b0, q.dvs};
				d.quo = {q.quo[COORD_W-2:0], 1'b1};
			end else begin
				d.rem = trial;
				d.quo = {q.quo[COORD_W-2:0], 1'b0};
			end
			d.cnt = q.cnt - 5'h01;
			if (q.cnt == 5'h01) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign calc.done     = q.done;
	assign calc.quotient = q.quo;
endmodule

// ===== rtl/lbag_width_mult.sv
/*
 * Forms rows times screen width as the sum of three selected
 * partial products, with no multiplier.
 * Assumes the quotient is held stable while the product is used.
 */
`timescale 1ns/1ps
module lbag_width_mult
	import lbag_pkg::*;
(
	// operands and product
	lbag_calc_if.mult calc
);
	// three shifted copies, each enabled by its own field
	assign calc.product = ppTerm(calc.ppA, calc.quotient)
		+ ppTerm(calc.ppB, calc.quotient)
		+ ppTerm(calc.ppC, calc.quotient);
endmodule

// ===== rtl/lbag_addr_gen.sv
/*
 * Localbuffer address generator: turns rasterizer fragments into
 * destination and copy-source addresses and texture indices into
 * packed texture-store word addresses, with two page detectors.
 * Assumes rasterizer, memory controller and APB master all run on
 * core_clk; memory requests hold until memReady is seen high.
 */
`timescale 1ns/1ps

module lbag_addr_gen
	import lbag_pkg::*;
(
	// clock and reset
	input  wire logic                             core_clk,
	input  wire logic                             rst_n,
	// apb slave
	input  wire logic [7:0]                       paddr,
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [31:0]                      pwdata,
	input  wire logic [3:0]                       pstrb,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	// fragments from the rasterizer
	input  wire logic                             fragValid,
	input  wire logic [lbag_pkg::COORD_W-1:0]     fragX,
	input  wire logic [lbag_pkg::COORD_W-1:0]     fragY,
	output logic                                  fragReady,
	// texture store requests
	input  wire logic                             texValid,
	input  wire logic [lbag_pkg::TEXIDX_W-1:0]    texIndex,
	output logic                                  texReady,
	// localbuffer memory side
	input  wire logic                             memReady,
	output logic                                  memValid,
	output logic      [lbag_pkg::ADDR_W-1:0]      memAddr,
	output logic      [lbag_pkg::ADDR_W-1:0]      memSrcAddr,
	output logic                                  memIsTexture,
	output logic                                  memPageHit,
	output logic      [2:0]                       memTexLane,
	output logic      [1:0]                       memTexDepth
);
	import lbag_pkg::*;

	typedef struct packed {
		lbag_state_t          st;
		logic [RM_W-1:0]      readMode;
		logic [ADDR_W-1:0]    winBase;
		logic [ADDR_W-1:0]    srcOff;
		logic [ADDR_W-1:0]    texBase;
		logic [15:0]          scrW;
		logic [15:0]          scrH;
		logic [SI_W-1:0]      scanInt;
		logic [1:0]           texDepth;
		logic                 pready;
		logic [31:0]          prdata;
		logic                 pslverr;
		logic [COORD_W-1:0]   x;
		logic                 start;
		logic                 fragReady;
		logic                 texReady;
		logic                 memValid;
		logic [ADDR_W-1:0]    memAddr;
		logic [ADDR_W-1:0]    memSrcAddr;
		logic                 memIsTex;
		logic                 memPageHit;
		logic [2:0]           memLane;
		logic [1:0]           memDepth;
		logic [ROW_W-1:0]     pixRow;
		logic [ROW_W-1:0]     texRow;
		logic                 pixOpen;
		logic                 texOpen;
		logic [COORD_W-1:0]   divY;
		logic [15:0]          discards;
		logic [15:0]          accepted;
	} lbag_main_t;

	lbag_main_t q;
	lbag_main_t d;

	lbag_calc_if calc ();

	// byte-lane merge of a write into an old register image
	function automatic logic [31:0] strbMerge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[8*b +: 8] = wd[8*b +: 8];
		end
		return r;
	endfunction

	// page detector: same row as the last open one
	function automatic logic pageMatch(
		input logic [ADDR_W-1:0] addr,
		input logic [ROW_W-1:0]  row,
		input logic              open
	);
		return open && (addr[ADDR_W-1:PAGE_BITS] == row);
	endfunction

	// widen a coordinate to an address
	function automatic logic [ADDR_W-1:0] widen(
		input logic [COORD_W-1:0] c
	);
		return {{(ADDR_W-COORD_W){1'b0}}, c};
	endfunction

	// arithmetic helpers
	lbag_y_divider u_div (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.calc     (calc.div)
	);

	lbag_width_mult u_mult (
		.calc (calc.mult)
	);

	// operands handed to the helpers
	assign calc.start    = q.start;
	assign calc.dividend = q.divY;
	assign calc.divisor  = q.scanInt;
	assign calc.ppA      = q.readMode[RM_PPA_LSB +: PP_W];
	assign calc.ppB      = q.readMode[RM_PPB_LSB +: PP_W];
	assign calc.ppC      = q.readMode[RM_PPC_LSB +: PP_W];

	logic              apbSetup;
	logic              apbDone;
	logic              fragTake;
	logic              texTake;
	logic              fragOut;
	logic [ADDR_W-1:0] rowsTimesW;
	logic [ADDR_W-1:0] dstAddr;
	logic [ADDR_W-1:0] wordIdx;
	logic [ADDR_W-1:0] texAddr;
	logic [2:0]        laneMask;
	logic [31:0]       rdWord;
	logic [31:0]       scrMerge;
	logic              rdOk;

	// handshake and decode terms
	always_comb begin
		apbSetup = psel && !penable && !q.pready;
		apbDone  = psel && penable && q.pready;
		fragTake = (q.st == ST_IDLE) && q.fragReady && fragValid;
		texTake  = (q.st == ST_IDLE) && q.texReady && texValid
			&& !fragValid;
		// negative or past the programmed extent is dropped
		fragOut  = fragX[COORD_W-1] || fragY[COORD_W-1]
			|| (fragX > q.scrW) || (fragY > q.scrH);
		rowsTimesW = calc.product;
		if (q.readMode[RM_ORIGIN_BIT])
			dstAddr = q.winBase - rowsTimesW + widen(q.x);
		else
			dstAddr = q.winBase + rowsTimesW + widen(q.x);
		// texels narrower than a word share it; lane picks the texel
		unique case (q.texDepth)
			TEX_D32: begin
				wordIdx  = texIndex;
				laneMask = 3'h0;
			end
			TEX_D16: begin
				wordIdx  = texIndex >> 1;
				laneMask = 3'h1;
			end
			TEX_D8: begin
				wordIdx  = texIndex >> 2;
				laneMask = 3'h3;
			end
			TEX_D4: begin
				wordIdx  = texIndex >> 3;
				laneMask = 3'h7;
			end
		endcase
		texAddr = q.texBase + wordIdx;
		scrMerge = strbMerge({q.scrH, q.scrW}, pwdata, pstrb);
	end

	// register read image
	always_comb begin
		rdOk   = 1'b1;
		rdWord = 32'h0;
		unique case (paddr)
			REG_READ_MODE: rdWord = 32'(q.readMode);
			REG_WIN_BASE:  rdWord = 32'(q.winBase);
			REG_SRC_OFF:   rdWord = 32'(q.srcOff);
			REG_SCREEN:    rdWord = {q.scrH, q.scrW};
			REG_SCAN_INT:  rdWord = 32'(q.scanInt);
			REG_TEX_CFG:   rdWord = 32'(q.texDepth);
			REG_TEX_BASE:  rdWord = 32'(q.texBase);
			REG_STATUS:    rdWord = {26'h0, q.texOpen, q.pixOpen,
				q.memValid, q.fragReady, q.st};
			REG_COUNTS:    rdWord = {q.accepted, q.discards};
			default:       rdOk = 1'b0;
		endcase
	end

	// next state of the whole block
	always_comb begin
		d = q;
		d.start = 1'b0;

		// apb: answer in the first access cycle
		d.pready = apbSetup;
		if (apbSetup) begin
			d.prdata  = pwrite ? 32'h0 : rdWord;
			d.pslverr = !rdOk || (pwrite && ((paddr == REG_STATUS)
				|| (paddr == REG_COUNTS)));
		end
		if (apbDone && pwrite && !q.pslverr) begin
			unique case (paddr)
				REG_READ_MODE: d.readMode = RM_W'(strbMerge(
					32'(q.readMode), pwdata, pstrb));
				REG_WIN_BASE: d.winBase = ADDR_W'(strbMerge(
					32'(q.winBase), pwdata, pstrb));
				REG_SRC_OFF: d.srcOff = ADDR_W'(strbMerge(
					32'(q.srcOff), pwdata, pstrb));
				REG_SCREEN: begin
					d.scrW = scrMerge[SCR_W_LSB +: 16];
					d.scrH = scrMerge[SCR_H_LSB +: 16];
				end
				REG_SCAN_INT: d.scanInt = SI_W'(strbMerge(
					32'(q.scanInt), pwdata, pstrb));
				REG_TEX_CFG: d.texDepth = 2'(strbMerge(
					32'(q.texDepth), pwdata, pstrb));
				REG_TEX_BASE: d.texBase = ADDR_W'(strbMerge(
					32'(q.texBase), pwdata, pstrb));
				default: d.readMode = q.readMode;
			endcase
		end

		// fragment and texture sequencing
		unique case (q.st)
			ST_IDLE: begin
				if (fragTake) begin
					if (fragOut) begin
						d.discards = q.discards + 16'h1;
					end else begin
						d.x         = fragX;
						d.divY      = fragY;
						d.start     = 1'b1;
						d.fragReady = 1'b0;
						d.texReady  = 1'b0;
						d.accepted  = q.accepted + 16'h1;
						d.st        = ST_DIVIDE;
					end
				end else if (texTake) begin
					d.memValid   = 1'b1;
					d.memAddr    = texAddr;
					d.memSrcAddr = texAddr;
					d.memIsTex   = 1'b1;
					d.memLane    = texIndex[2:0] & laneMask;
					d.memDepth   = q.texDepth;
					d.memPageHit = pageMatch(texAddr, q.texRow,
						q.texOpen);
					d.fragReady  = 1'b0;
					d.texReady   = 1'b0;
					d.st         = ST_ISSUE;
				end
			end
			ST_DIVIDE: begin
				if (calc.done)
					d.st = ST_ADDRESS;
			end
			ST_ADDRESS: begin
				d.memValid   = 1'b1;
				d.memAddr    = dstAddr;
				d.memSrcAddr = dstAddr + q.srcOff;
				d.memIsTex   = 1'b0;
				d.memLane    = 3'h0;
				d.memDepth   = TEX_D32;
				d.memPageHit = pageMatch(dstAddr, q.pixRow,
					q.pixOpen);
				d.st         = ST_ISSUE;
			end
			ST_ISSUE: begin
				if (memReady) begin
					// each detector remembers only its own stream
					if (q.memIsTex) begin
						d.texRow  = q.memAddr[ADDR_W-1:PAGE_BITS];
						d.texOpen = 1'b1;
					end else begin
						d.pixRow  = q.memAddr[ADDR_W-1:PAGE_BITS];
						d.pixOpen = 1'b1;
					end
					d.memValid  = 1'b0;
					d.fragReady = 1'b1;
					d.texReady  = 1'b1;
					d.st        = ST_IDLE;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q           <= '0;
			q.st        <= ST_IDLE;
			q.scanInt   <= RST_SCAN_INT;
			q.scrW      <= RST_SCR_EXT;
			q.scrH      <= RST_SCR_EXT;
			q.fragReady <= 1'b1;
			q.texReady  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign prdata       = q.prdata;
	assign pready       = q.pready;
	assign pslverr      = q.pslverr;
	assign fragReady    = q.fragReady;
	assign texReady     = q.texReady;
	assign memValid     = q.memValid;
	assign memAddr      = q.memAddr;
	assign memSrcAddr   = q.memSrcAddr;
	assign memIsTexture = q.memIsTex;
	assign memPageHit   = q.memPageHit;
	assign memTexLane   = q.memLane;
	assign memTexDepth  = q.memDepth;
endmodule

// ===== test/lbag_addr_gen_checker.sv
/*
 * Port-level assertions for the localbuffer address generator.
 * Assumes one core clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module lbag_addr_gen_checker
	import lbag_pkg::*;
(
	// clock and reset
	input wire logic                          core_clk,
	input wire logic                          rst_n,
	// apb handshake
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pready,
	// fragment and texture side
	input wire logic                          fragValid,
	input wire logic [lbag_pkg::COORD_W-1:0]  fragX,
	input wire logic [lbag_pkg::COORD_W-1:0]  fragY,
	input wire logic                          fragReady,
	input wire logic                          texValid,
	input wire logic                          texReady,
	// memory side
	input wire logic                          memReady,
	input wire logic                          memValid,
	input wire logic [lbag_pkg::ADDR_W-1:0]   memAddr,
	input wire logic [lbag_pkg::ADDR_W-1:0]   memSrcAddr,
	input wire logic                          memIsTexture,
	input wire logic [2:0]                    memTexLane,
	input wire logic [1:0]                    memTexDepth
);
	import lbag_pkg::*;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// register access answered in the first access cycle
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("apb answer missing");
	chk_tex_src_same: assert property (memValid && memIsTexture |->
		memSrcAddr == memAddr) else $error("texture source differs");
	chk_lane_packing: assert property (memValid && memIsTexture |->
		memTexLane <= 3'((4'h1 << memTexDepth) - 4'h1))
		else $error("texel lane beyond packing");
	chk_pix_word_only: assert property (memValid && !memIsTexture |->
		memTexLane == 3'h0 && memTexDepth == 2'h0)
		else $error("pixel access carries lane");
	chk_tex_answer: assert property (texValid && texReady && !fragValid
		|=> memValid && memIsTexture) else $error("texture answer late");
	// negative coordinates leave no memory access
	chk_discard_quiet: assert property (fragValid && fragReady &&
		(fragX[15] || fragY[15]) |=> fragReady && !memValid)
		else $error("negative fragment not dropped");
	chk_busy_refuse: assert property (memValid |->
		!fragReady && !texReady) else $error("ready while busy");
	chk_req_hold: assert property (memValid && !memReady |=>
		memValid && $stable(memAddr) && $stable(memSrcAddr))
		else $error("request dropped or changed");
	chk_frag_latency: assert property (fragValid && fragReady &&
		!fragX[15] && !fragY[15] |=> !memValid [*2])
		else $error("fragment answered too soon");
endmodule

bind lbag_addr_gen lbag_addr_gen_checker lbag_addr_gen_checker_inst (
	.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pready(pready), .fragValid(fragValid), .fragX(fragX), .fragY(fragY),
	.fragReady(fragReady), .texValid(texValid), .texReady(texReady),
	.memReady(memReady), .memValid(memValid), .memAddr(memAddr),
	.memSrcAddr(memSrcAddr), .memIsTexture(memIsTexture),
	.memTexLane(memTexLane), .memTexDepth(memTexDepth)
);

// ===== test/lbag_mem_model.sv
/*
 * Localbuffer memory responder: answers after a chosen stall and
 * records what each finished access carried.
 * Assumes requests hold until memReady is seen high.
 */
`timescale 1ns/1ps
module lbag_mem_model
	import lbag_pkg::*;
(
	// clock and reset
	input wire logic                         core_clk,
	input wire logic                         rst_n,
	// request from the generator
	input wire logic                         memValid,
	input wire logic [lbag_pkg::ADDR_W-1:0]  memAddr,
	input wire logic [lbag_pkg::ADDR_W-1:0]  memSrcAddr,
	input wire logic                         memPageHit,
	input wire logic [2:0]                   memTexLane,
	input wire logic [1:0]                   memTexDepth,
	input wire logic [3:0]                   stall,
	output logic                             memReady,
	// capture of the last finished access
	output logic [lbag_pkg::ADDR_W-1:0]      gotAddr,
	output logic [lbag_pkg::ADDR_W-1:0]      gotSrc,
	output logic                             gotHit,
	output logic [2:0]                       gotLane,
	output logic [1:0]                       gotDepth,
	output logic [7:0]                       gotCnt
);
	import lbag_pkg::*;
	logic [3:0] waitCnt;

	// stall, then answer; capture at the finishing edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			memReady <= 1'b0;
			waitCnt  <= '0;
			gotCnt   <= '0;
		end else if (memValid && memReady) begin
			memReady <= 1'b0;
			waitCnt  <= '0;
			gotAddr  <= memAddr;
			gotSrc   <= memSrcAddr;
			gotHit   <= memPageHit;
			gotLane  <= memTexLane;
			gotDepth <= memTexDepth;
			gotCnt   <= gotCnt + 8'h01;
		end else if (memValid) begin
			if (waitCnt >= stall)
				memReady <= 1'b1;
			else
				waitCnt <= waitCnt + 4'h1;
		end
	end
endmodule

// ===== test/lbag_addr_gen_tb_top.sv
/*
 * Testbench for the address generator: apb register access,
 * fragment and texture requests against the memory responder.
 * Assumes a 125 MHz core clock.
 */
`timescale 1ns/1ps
module lbag_addr_gen_tb_top;
	import lbag_pkg::*;
	localparam int PA = 6;
	localparam int PB = 4;
	localparam int W  = (1 << (PA + PP_BASE_SHIFT)) + (1 << (PB + PP_BASE_SHIFT));
	localparam logic [23:0] B = 24'h100000;
	localparam logic [23:0] O = 24'h000200;
	localparam logic [23:0] T = 24'h200000;
	localparam logic [23:0] IX = 24'h000123;

	logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdData;
	logic [3:0]  pstrb, stall;
	logic        fragValid, fragReady, texValid, texReady, rdErr;
	logic [15:0] fragX, fragY;
	logic [23:0] texIndex, memAddr, memSrcAddr, gotAddr, gotSrc, ea;
	logic        memReady, memValid, memIsTexture, memPageHit, gotHit;
	logic [2:0]  memTexLane, gotLane;
	logic [1:0]  memTexDepth, gotDepth;
	logic [7:0]  gotCnt;
	int          error_cnt, tests_run;

	lbag_addr_gen lbag_addr_gen_inst (.core_clk(core_clk), .rst_n(rst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fragValid(fragValid), .fragX(fragX),
		.fragY(fragY), .fragReady(fragReady), .texValid(texValid),
		.texIndex(texIndex), .texReady(texReady), .memReady(memReady),
		.memValid(memValid), .memAddr(memAddr), .memSrcAddr(memSrcAddr),
		.memIsTexture(memIsTexture), .memPageHit(memPageHit),
		.memTexLane(memTexLane), .memTexDepth(memTexDepth));
	lbag_mem_model lbag_mem_model_inst (.core_clk(core_clk), .rst_n(rst_n),
		.memValid(memValid), .memAddr(memAddr), .memSrcAddr(memSrcAddr),
		.memPageHit(memPageHit), .memTexLane(memTexLane), .stall(stall),
		.memReady(memReady), .gotAddr(gotAddr), .gotSrc(gotSrc),
		.gotHit(gotHit), .gotLane(gotLane), .gotCnt(gotCnt),
		.memTexDepth(memTexDepth), .gotDepth(gotDepth));

	// clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one apb transfer; result kept in rdData and rdErr
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rdData = prdata;
		rdErr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// one fragment or texture request, then compare the access seen
	task automatic req(input logic tex, input logic [23:0] a,
		input logic [15:0] y, input logic ok, input logic [23:0] eSrc,
		input logic hit, input logic [2:0] ln);
		int n;
		n = gotCnt;
		@(posedge core_clk);
		if (tex) begin
			texValid <= 1'b1;
			texIndex <= a;
		end else begin
			fragValid <= 1'b1;
			fragX     <= a[15:0];
			fragY     <= y;
		end
		// hold the offer until the generator is seen ready at an edge
		do @(posedge core_clk);
		while ((tex ? texReady : fragReady) !== 1'b1);
		texValid  <= 1'b0;
		fragValid <= 1'b0;
		repeat (40) begin
			@(negedge core_clk);
			if (gotCnt != 8'(n)) break;
		end
		check("access count", 32'(gotCnt), 32'(ok ? n + 1 : n));
		if (ok) begin
			check("address", 32'(gotAddr), 32'(ea));
			check("source", 32'(gotSrc), 32'(eSrc));
			check("page hit", 32'(gotHit), 32'(hit));
			check("lane", 32'(gotLane), 32'(ln));
		end
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		close_out();
	end

	// main sequence; reset values are read back first
	initial begin
		{psel, penable, pwrite, paddr, pwdata, fragValid, texValid} = '0;
		{fragX, fragY, texIndex, stall, error_cnt, tests_run} = '0;
		pstrb = 4'hf;
		rst_n = 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, REG_SCAN_INT, 32'h0);
		check("interval reset", rdData, 32'h1);
		apb(1'b0, REG_SCREEN, 32'h0);
		check("screen reset", rdData, 32'hffffffff);
		apb(1'b0, REG_READ_MODE, 32'h0);
		check("mode reset", rdData, 32'h0);
		apb(1'b1, REG_STATUS, 32'h5);
		check("read-only write", 32'(rdErr), 32'h1);
		apb(1'b0, 8'h24, 32'h0);
		check("unmapped read", 32'(rdErr), 32'h1);
		apb(1'b1, REG_READ_MODE, 32'((PB << RM_PPB_LSB) | (PA << RM_PPA_LSB)));
		apb(1'b1, REG_WIN_BASE, 32'(B));
		apb(1'b1, REG_SRC_OFF, 32'(O));
		apb(1'b1, REG_SCREEN, {16'd50, 16'd100});
		apb(1'b1, REG_TEX_BASE, 32'(T));
		// top-left, interval one, then same row again with a slow memory
		ea = 24'(B + 3 * W + 5);
		req(1'b0, 24'd5, 16'd3, 1'b1, ea + O, 1'b0, 3'h0);
		stall = 4'h3;
		ea = 24'(B + 3 * W + 6);
		req(1'b0, 24'd6, 16'd3, 1'b1, ea + O, 1'b1, 3'h0);
		// every texel depth
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, REG_TEX_CFG, 32'(d));
			ea = T + (IX >> d);
			req(1'b1, IX, 16'd0, 1'b1, ea, d != 0,
				IX[2:0] & 3'((1 << d) - 1));
			check("depth", 32'(gotDepth), 32'(d));
		end
		ea = 24'(B + 3 * W + 7);
		req(1'b0, 24'd7, 16'd3, 1'b1, ea + O, 1'b1, 3'h0);
		// bottom-left with interval two
		apb(1'b1, REG_READ_MODE, 32'((PB << RM_PPB_LSB) | (PA << RM_PPA_LSB) | 1));
		apb(1'b1, REG_SCAN_INT, 32'h2);
		ea = 24'(B - 3 * W + 5);
		req(1'b0, 24'd5, 16'd7, 1'b1, ea + O, 1'b0, 3'h0);
		ea = 24'(B - 25 * W + 100);
		req(1'b0, 24'd100, 16'd50, 1'b1, ea + O, 1'b0, 3'h0);
		// out of range fragments are dropped
		req(1'b0, 24'd101, 16'd0, 1'b0, 24'h0, 1'b0, 3'h0);
		req(1'b0, 24'h00ffff, 16'd0, 1'b0, 24'h0, 1'b0, 3'h0);
		req(1'b0, 24'd0, 16'h8000, 1'b0, 24'h0, 1'b0, 3'h0);
		apb(1'b0, REG_COUNTS, 32'h0);
		check("discards", 32'(rdData[15:0]), 32'd3);
		check("accepted", 32'(rdData[31:16]), 32'd5);
		close_out();
	end
endmodule
